/* pkg/rxf_pkg.sv */
// Function
// - Destination and source are six-byte fields
// - Frames failing the filter are not received
// - All controls zero: perfect match every frame
// - Hash-perfect: perfect physical, hash multicast
// - Hash-only plus hash-perfect: hash all frames
// - Inverse: accept only non-matching destinations
// - Pass-multicast: multicast passes, physical perfect/hash
// - Perfect match against concatenated station address
// - Upper six CRC bits index 64-bit table
// - Index top bit picks high/low hash word
// - Hash-perfect multicast uses same hash process
// - Pass-multicast accepts in every mode, promiscuous in every mode but inverse
// - Wake enable stops reception, detection sets flag
// - Wake report selectable: interrupt or power event
// - Four filters; address check plus CRC compare
// - 31-bit byte mask from offset feeds CRC
// - Command bit 3 address type, bit 0 enable
// - Low power state forces wake detection on
// - Broadcast wake frame ignores broadcast disable
// - Eight-bit offset, zero is first destination byte
// - Sixteen-bit expected CRC compared per filter
package rxf_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MAC_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATION_HI = 8'h04;
  localparam logic [7:0] ADDR_STATION_LO = 8'h08;
  localparam logic [7:0] ADDR_HASH_HI = 8'h0c;
  localparam logic [7:0] ADDR_HASH_LO = 8'h10;
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h14;
  localparam logic [7:0] ADDR_WAKE_PORT = 8'h18;
  // Control register bit positions
  localparam int BIT_PASS_MC = 0;
  localparam int BIT_PROMISC = 1;
  localparam int BIT_INVERSE = 2;
  localparam int BIT_HASH_ONLY = 3;
  localparam int BIT_HASH_PERF = 4;
  localparam int BIT_BROADCAST_DISABLE_DIS = 5;
  // Wake control/status bit positions
  localparam int BIT_WAKE_EN = 0;
  localparam int BIT_WAKE_RCVD = 1;
  localparam int BIT_WAKE_PME = 2;
  localparam int BIT_WAKE_ACT = 3;
  // Filter command fields
  localparam int BIT_CMD_EN = 0;
  localparam int BIT_CMD_MC = 3;
  // Reset values and CRC constants
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] CRC32_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC32_POLY = 32'hedb8_8320;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [15:0] CRC16_POLY = 16'ha001;
  // Frame geometry
  localparam int ADDR_BYTES = 6;
  localparam int MASK_BITS = 31;
  localparam int PORT_WORDS = 8;
  // Receive sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_BODY = 3'b100
  } rxf_state_t;
endpackage

/* sim/rxf_filter_sva.sv */
`timescale 1ns/10ps
module rxf_filter_chk #(
  parameter int NUM_FILT = 4,
  parameter int CNT_W = 11
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Receive stream and power state
  input wire logic rx_valid,
  input wire logic rx_eof,
  input wire logic low_power_state,
  // Outcomes
  input wire logic frame_accept,
  input wire logic frame_reject,
  input wire logic host_irq,
  input wire logic power_event_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  // Never both verdicts at once
  property p_one_verdict;
    !(frame_accept && frame_reject);
  endproperty
  a_one_verdict: assert property (p_one_verdict)
    else $error("two verdicts");
  // Every last byte earns a verdict the next cycle
  property p_verdict_due;
    rx_valid && rx_eof |=> frame_accept || frame_reject;
  endproperty
  a_verdict_due: assert property (p_verdict_due)
    else $error("verdict missing");
  // A verdict only ever follows a last byte
  property p_verdict_cause;
    frame_accept || frame_reject |-> $past(rx_valid && rx_eof);
  endproperty
  a_verdict_cause: assert property (p_verdict_cause)
    else $error("stray verdict");
  // Only one report path is chosen
  property p_one_report;
    !(host_irq && power_event_output);
  endproperty
  a_one_report: assert property (p_one_report)
    else $error("both reports");
  // A report rises two edges after a last byte
  property p_report_cause;
    $rose(host_irq || power_event_output) |-> $past(rx_valid && rx_eof, 2);
  endproperty
  a_report_cause: assert property (p_report_cause)
    else $error("report without frame");
  // Places above wake control, the write-only port among them, read as zero
  property p_read_zero;
    $past(rd) && ($past(addr) > rxf_pkg::ADDR_WAKE_CTRL) |-> rdata == rxf_pkg::RST_WORD;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("nonzero read");
  // Low power forces detection on, seen in the status bit
  property p_lp_active;
    $past(rd) && $past(addr) == rxf_pkg::ADDR_WAKE_CTRL && $past(low_power_state)
      && $past(low_power_state, 2) |-> rdata[rxf_pkg::BIT_WAKE_ACT];
  endproperty
  a_lp_active: assert property (p_lp_active)
    else $error("detection not active");
  // Normal reception stops while low power holds
  property p_lp_no_accept;
    frame_accept |-> !($past(low_power_state) && $past(low_power_state, 2));
  endproperty
  a_lp_no_accept: assert property (p_lp_no_accept)
    else $error("accept in low power");
endmodule // rxf_filter_chk

/* sim/rxf_rx_src.sv */
`timescale 1ns/10ps
module rxf_rx_src (
  // Clock
  input wire logic clock,
  // Byte stream towards the filter
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_data
);
  logic [7:0] frm [64]; // Frame bytes, destination first
  //////////////////////////////////////////////////////////////////////
  // Idle at time zero
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
  end
  // Send len bytes; slow leaves a gap after each byte but the last
  // Idle data is inverted so a stale byte is never mistaken
  task automatic send(input int len, input bit slow);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == len - 1);
      rx_data <= frm[i];
      if (slow && i < len - 1) begin
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~frm[i];
      end
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule // rxf_rx_src

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
  // Design pins
  logic clock, rst_b, clk_en, wr, rd, low_power_state;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic rx_valid, rx_sof, rx_eof, frame_accept, frame_reject, host_irq, power_event_output;
  logic [7:0] rx_data;
  // Bench state
  int err_count, cmp_count;
  logic [47:0] sta; // Station address
  logic [47:0] d; // Current destination
  logic [63:0] hsh; // Hash table, high word on top
  logic [31:0] wv [8]; // Filter port words
  logic [31:0] v;
  logic [4:0] md [9] = '{5'h00, 5'h10, 5'h18, 5'h04, 5'h02, 5'h1b, 5'h01, 5'h11, 5'h19};
  //////////////////////////////////////////////////////////////////////
  rxf_filter dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data), .low_power_state(low_power_state), .frame_accept(frame_accept),
    .frame_reject(frame_reject), .host_irq(host_irq), .power_event_output(power_event_output));
  rxf_rx_src src (.clock(clock), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data));
  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////
  // Hash index: reflected CRC-32 over the destination, top six bits
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 47; i >= 7; i -= 8)
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ a[i - 7 + b]) ? 32'hedb8_8320 : 32'h0000_0000);
    return c[31:26];
  endfunction
  // Pattern CRC-16 over masked bytes from the offset
  function automatic logic [15:0] c16(input int off, input logic [30:0] m);
    logic [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < 31; j++)
      if (m[j])
        for (int b = 0; b < 8; b++)
          c = (c >> 1) ^ ((c[0] ^ src.frm[off + j][b]) ? 16'ha001 : 16'h0000);
    return c;
  endfunction
  // Expected verdict for a control setting; promiscuous wins outside inverse, then pass-multicast
  function automatic logic exp_acc(input logic [4:0] c, input logic [47:0] a);
    logic mc, pf, hs;
    mc = a[40];
    pf = (a == sta);
    hs = hsh[hidx(a)];
    if (c[1] && !c[2]) return 1'b1;
    if (c[0] && mc) return 1'b1;
    if (c[2]) return !pf;
    if (c[3] && c[4]) return hs;
    if (c[4] && mc) return hs;
    return pf;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read: data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    x = rdata;
  endtask
  // Load a destination into the first six bytes
  task automatic put_dest(input logic [47:0] a);
    for (int i = 0; i < 6; i++) src.frm[i] = a[47 - 8 * i -: 8];
  endtask
  // Send a frame; verdict shows one cycle after the last byte
  task automatic xfer(input int len, input bit slow, input logic ea);
    src.send(len, slow);
    #1;
    chk(frame_accept, ea, "accept");
    chk(frame_reject, !ea, "reject");
  endtask
  // Eight port writes; k spoils the CRC of filter 0
  task automatic prog(input logic [15:0] k);
    wv[6] = {c16(12, wv[1][30:0]), c16(14, wv[0][30:0]) ^ k};
    for (int i = 0; i < 8; i++) wr_reg(rxf_pkg::ADDR_WAKE_PORT, wv[i]);
  endtask
  // Report after the edge that follows a wake verdict
  task automatic rep(input logic ei, input logic ep);
    @(posedge clock);
    #1;
    chk(host_irq, ei, "irq");
    chk(power_event_output, ep, "power event");
  endtask
  // Single exit point
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Hang guard, well above the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(15));
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    low_power_state = 1'b0;
    clk_en = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(rxf_pkg::ADDR_MAC_CONTROL, v);
    chk(v, 32'h0000_0000, "control reset");
    // A write while the clock enable is low must not land
    @(posedge clock);
    clk_en <= 1'b0;
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_001f);
    clk_en <= 1'b1;
    rd_reg(rxf_pkg::ADDR_MAC_CONTROL, v);
    chk(v, 32'h0000_0000, "frozen control");
    sta[47:16] = $urandom;
    sta[15:0] = 16'($urandom);
    sta[40] = 1'b0;
    hsh = {$urandom, $urandom};
    wr_reg(rxf_pkg::ADDR_STATION_HI, {16'h0000, sta[47:32]});
    wr_reg(rxf_pkg::ADDR_STATION_LO, sta[31:0]);
    wr_reg(rxf_pkg::ADDR_HASH_HI, hsh[63:32]);
    wr_reg(rxf_pkg::ADDR_HASH_LO, hsh[31:0]);
    rd_reg(rxf_pkg::ADDR_STATION_HI, v);
    chk(v[15:0], sta[47:32], "station");
    rd_reg(8'h1c, v);
    chk(v, 32'h0000_0000, "unmapped");
    rd_reg(rxf_pkg::ADDR_WAKE_PORT, v);
    chk(v, 32'h0000_0000, "port");
    $display("test registers done");
    for (int i = 6; i < 64; i++) src.frm[i] = 8'($urandom);
    // Every mode row: station, near miss, random destinations
    foreach (md[m]) begin
      wr_reg(rxf_pkg::ADDR_MAC_CONTROL, {27'h0, md[m]});
      for (int j = 0; j < 6; j++) begin
        d = (j == 0) ? sta : (j == 1) ? sta ^ 48'h1 : {$urandom, 16'($urandom)};
        put_dest(d);
        xfer(20, j[0], exp_acc(md[m], d));
      end
    end
    xfer(5, 1'b0, 1'b0);
    $display("test modes done");
    // Wake filters: f0 unicast at 14, f1 multicast at 12
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_0000);
    put_dest(sta);
    wv[0] = $urandom & 32'h7fff_ffff;
    wv[1] = $urandom & 32'h7fff_ffff;
    wv[2] = 32'h0000_0000;
    wv[3] = 32'h0000_0000;
    wv[4] = 32'h0000_0901;
    wv[5] = 32'h1e14_0c0e;
    wv[7] = $urandom;
    prog(16'h0000);
    wr_reg(rxf_pkg::ADDR_WAKE_CTRL, 32'h0000_0001);
    xfer(48, 1'b1, 1'b0);
    rep(1'b1, 1'b0);
    rd_reg(rxf_pkg::ADDR_WAKE_CTRL, v);
    chk(v[1], 1'b1, "received flag");
    // Spoil f0; a multicast-only filter must ignore a unicast frame
    prog(16'h0001);
    wr_reg(rxf_pkg::ADDR_WAKE_CTRL, 32'h0000_0003);
    xfer(48, 1'b0, 1'b0);
    rep(1'b0, 1'b0);
    // Broadcast still wakes with broadcast disabled
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_0020);
    put_dest(48'hffff_ffff_ffff);
    xfer(48, 1'b0, 1'b0);
    rep(1'b1, 1'b0);
    $display("test wake enable done");
    // Low power forces detection; report on the power event line
    wr_reg(rxf_pkg::ADDR_WAKE_CTRL, 32'h0000_0006);
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_0000);
    prog(16'h0000);
    @(posedge clock);
    low_power_state <= 1'b1;
    put_dest(sta);
    xfer(48, 1'b0, 1'b0);
    rep(1'b0, 1'b1);
    rd_reg(rxf_pkg::ADDR_WAKE_CTRL, v);
    chk(v[3], 1'b1, "detect active");
    @(posedge clock);
    low_power_state <= 1'b0;
    wr_reg(rxf_pkg::ADDR_WAKE_CTRL, 32'h0000_0006);
    xfer(48, 1'b0, 1'b1);
    rep(1'b0, 1'b0);
    $display("test low power done");
    // Broadcast disable drops broadcasts except in promiscuous mode
    put_dest(48'hffff_ffff_ffff);
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_0021);
    xfer(20, 1'b1, 1'b0);
    wr_reg(rxf_pkg::ADDR_MAC_CONTROL, 32'h0000_0022);
    xfer(20, 1'b0, 1'b1);
    $display("test broadcast done");
    end_of_test();
  end
endmodule // testbench

bind rxf_filter rxf_filter_chk #(.NUM_FILT(NUM_FILT), .CNT_W(CNT_W)) u_chk (.clock(clock),
  .rst_b(rst_b), .addr(addr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_eof(rx_eof),
  .low_power_state(low_power_state), .frame_accept(frame_accept),
  .frame_reject(frame_reject), .host_irq(host_irq), .power_event_output(power_event_output));

/* verilog/rxf_filter.sv */
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module rxf_filter #(
  parameter int NUM_FILT = 4,
  parameter int CNT_W = 11
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Receive byte stream
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  // Power state, high while in the lower power state
  input wire logic low_power_state,
  // Frame decision and wake reporting
  output logic frame_accept,
  output logic frame_reject,
  output logic host_irq,
  output logic power_event_output
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Reflected CRC-32 step over one byte, lsb first
  function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                             input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ rxf_pkg::CRC32_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Reflected CRC-16 step over one byte, lsb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ rxf_pkg::CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [5:0] ctrl_r; // Filter mode controls
  logic [15:0] sta_hi_r; // Station address bytes 0..1
  logic [31:0] sta_lo_r; // Station address bytes 2..5
  logic [31:0] hash_hi_r; // Hash table bits 32..63
  logic [31:0] hash_lo_r; // Hash table bits 0..31
  logic wake_en_r; // Wake frame enable
  logic wake_rcvd_r; // Wake frame received flag
  logic wake_pme_r; // 1: report on power event, 0: on interrupt
  logic [2:0] port_ptr_r; // Next filter port word
  logic [31:0] port_r [rxf_pkg::PORT_WORDS]; // Filter port words
  logic [31:0] rdata_r;
  logic wake_hit; // Detection at end of frame

  // Wake detection is forced on in the lower power state
  logic wake_act;
  assign wake_act = wake_en_r | low_power_state;

  // Mode control register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_r <= 6'h00;
    end else if (clk_en && wr && addr == rxf_pkg::ADDR_MAC_CONTROL) begin
      ctrl_r <= wdata[5:0];
    end
  end

  // Station address and hash table
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sta_hi_r <= rxf_pkg::RST_WORD[15:0];
      sta_lo_r <= rxf_pkg::RST_WORD;
      hash_hi_r <= rxf_pkg::RST_WORD;
      hash_lo_r <= rxf_pkg::RST_WORD;
    end else if (clk_en && wr) begin
      if (addr == rxf_pkg::ADDR_STATION_HI) begin
        sta_hi_r <= wdata[15:0];
      end else if (addr == rxf_pkg::ADDR_STATION_LO) begin
        sta_lo_r <= wdata;
      end else if (addr == rxf_pkg::ADDR_HASH_HI) begin
        hash_hi_r <= wdata;
      end else if (addr == rxf_pkg::ADDR_HASH_LO) begin
        hash_lo_r <= wdata;
      end
    end
  end

  // Wake control; a detection in the clearing cycle keeps the flag
  // Received bit clears on a written one, so a plain enable write keeps it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wake_en_r <= 1'b0;
      wake_rcvd_r <= 1'b0;
      wake_pme_r <= 1'b0;
    end else if (clk_en) begin
      if (wr && addr == rxf_pkg::ADDR_WAKE_CTRL) begin
        wake_en_r <= wdata[rxf_pkg::BIT_WAKE_EN];
        wake_pme_r <= wdata[rxf_pkg::BIT_WAKE_PME];
      end
      if (wake_hit) begin
        wake_rcvd_r <= 1'b1;
      end else if (wr && addr == rxf_pkg::ADDR_WAKE_CTRL
                   && wdata[rxf_pkg::BIT_WAKE_RCVD]) begin
        wake_rcvd_r <= 1'b0;
      end
    end
  end

  // Filter port: words land in order, pointer wraps after eight
  // Software must write all eight words; a partial load shifts the rest
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      port_ptr_r <= 3'h0;
      for (int i = 0; i < rxf_pkg::PORT_WORDS; i++) begin
        port_r[i] <= rxf_pkg::RST_WORD;
      end
    end else if (clk_en && wr && addr == rxf_pkg::ADDR_WAKE_PORT) begin
      port_r[port_ptr_r] <= wdata;
      port_ptr_r <= port_ptr_r + 3'h1;
    end
  end

  // Read data, valid the cycle after the strobe only
  // Holes and the write-only filter port read back as zero
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_r <= rxf_pkg::RST_WORD;
    end else if (clk_en) begin
      rdata_r <= rxf_pkg::RST_WORD;
      if (rd) begin
        if (addr == rxf_pkg::ADDR_MAC_CONTROL) begin
          rdata_r <= {26'h000_0000, ctrl_r};
        end else if (addr == rxf_pkg::ADDR_STATION_HI) begin
          rdata_r <= {16'h0000, sta_hi_r};
        end else if (addr == rxf_pkg::ADDR_STATION_LO) begin
          rdata_r <= sta_lo_r;
        end else if (addr == rxf_pkg::ADDR_HASH_HI) begin
          rdata_r <= hash_hi_r;
        end else if (addr == rxf_pkg::ADDR_HASH_LO) begin
          rdata_r <= hash_lo_r;
        end else if (addr == rxf_pkg::ADDR_WAKE_CTRL) begin
          rdata_r <= {28'h000_0000, wake_act, wake_pme_r,
                      wake_rcvd_r, wake_en_r};
        end
      end
    end
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////
  // Receive sequencer and destination capture

  rxf_pkg::rxf_state_t state_r;
  logic [CNT_W-1:0] cnt_r; // Index of the next byte
  logic [47:0] dst_r; // Destination, first byte in the top
  logic [31:0] hcrc_r; // Hash CRC over the destination
  logic [CNT_W-1:0] idx; // Index of the byte now on rx_data
  logic [47:0] dst_now; // Destination including this byte
  logic [31:0] hcrc_now; // Hash CRC including this byte

  // The first byte restarts everything, even mid-frame
  assign idx = rx_sof ? '0 : cnt_r;
  assign dst_now = (idx < CNT_W'(rxf_pkg::ADDR_BYTES))
                   ? {dst_r[39:0], rx_data} : dst_r;
  assign hcrc_now = (idx < CNT_W'(rxf_pkg::ADDR_BYTES))
                    ? crc32_byte(rx_sof ? rxf_pkg::CRC32_INIT : hcrc_r,
                                 rx_data)
                    : hcrc_r;

  // Sequencer; count saturates so long frames do not wrap
  // Bytes past the counter's range share the last index, harmless here
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= rxf_pkg::ST_IDLE;
      cnt_r <= '0;
      dst_r <= 48'h0000_0000_0000;
      hcrc_r <= rxf_pkg::CRC32_INIT;
    end else if (clk_en && rx_valid) begin
      dst_r <= dst_now;
      hcrc_r <= hcrc_now;
      if (cnt_r != '1 || rx_sof) begin
        cnt_r <= idx + CNT_W'(1);
      end
      case (state_r)
        rxf_pkg::ST_IDLE: begin
          if (rx_sof && !rx_eof) begin
            state_r <= rxf_pkg::ST_ADDR;
          end
        end
        rxf_pkg::ST_ADDR: begin
          if (rx_eof) begin
            state_r <= rxf_pkg::ST_IDLE;
          end else if (idx == CNT_W'(rxf_pkg::ADDR_BYTES - 1)) begin
            state_r <= rxf_pkg::ST_BODY;
          end
        end
        rxf_pkg::ST_BODY: begin
          if (rx_eof) begin
            state_r <= rxf_pkg::ST_IDLE;
          end else if (rx_sof) begin
            state_r <= rxf_pkg::ST_ADDR;
          end
        end
        default: begin
          state_r <= rxf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address decision, evaluated on the last byte

  logic [47:0] station;
  logic is_mc; // First destination bit on the wire
  logic is_bc;
  logic perfect;
  logic [5:0] hidx;
  logic hash_hit;
  logic addr_ok; // Mode decision without broadcast disable
  logic bc_ok;
  logic long_enough;

  assign station = {sta_hi_r, sta_lo_r};
  assign is_mc = dst_now[40];
  assign is_bc = &dst_now;
  assign perfect = (dst_now == station);
  assign hidx = hcrc_now[31:26];
  assign hash_hit = hidx[5] ? hash_hi_r[hidx[4:0]]
                            : hash_lo_r[hidx[4:0]];
  assign long_enough = (idx >= CNT_W'(rxf_pkg::ADDR_BYTES - 1));

  // Mode table; pass-multicast and promiscuous (outside inverse) dominate
  always_comb begin
    addr_ok = 1'b0;
    if (ctrl_r[rxf_pkg::BIT_PROMISC] && !ctrl_r[rxf_pkg::BIT_INVERSE]) begin
      addr_ok = 1'b1;
    end else if (is_mc && ctrl_r[rxf_pkg::BIT_PASS_MC]) begin
      addr_ok = 1'b1;
    end else if (ctrl_r[rxf_pkg::BIT_INVERSE]) begin
      addr_ok = !perfect;
    end else if (is_mc && ctrl_r[rxf_pkg::BIT_HASH_PERF]) begin
      addr_ok = hash_hit;
    end else if (ctrl_r[rxf_pkg::BIT_HASH_ONLY]
                 && ctrl_r[rxf_pkg::BIT_HASH_PERF]) begin
      addr_ok = hash_hit;
    end else begin
      addr_ok = perfect;
    end
  end

  // Broadcast disable does not bind promiscuous mode
  assign bc_ok = !(is_bc && ctrl_r[rxf_pkg::BIT_BROADCAST_DISABLE_DIS]
                   && !ctrl_r[rxf_pkg::BIT_PROMISC]);

  ////////////////////////////////////////////////////////////////////
  // Wake pattern filters

  logic [NUM_FILT-1:0] filt_hit;
  logic wake_addr_ok;

  // Broadcast wake frames pass whatever broadcast disable says
  assign wake_addr_ok = addr_ok || is_bc;

  generate
    for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
      logic [31:0] mask;
      logic [7:0] cmd;
      logic [7:0] offs;
      logic [15:0] exp_crc;
      logic [15:0] crc_r;
      logic [15:0] crc_seed;
      logic [15:0] crc_now;
      logic [CNT_W-1:0] rel;
      logic take;

      assign mask = port_r[f];
      assign cmd = port_r[4][8*f +: 8];
      assign offs = port_r[5][8*f +: 8];
      assign exp_crc = port_r[6 + f/2][16*(f%2) +: 16];
      // Byte offset+j feeds the CRC when mask bit j is set
      assign rel = idx - CNT_W'(offs);
      assign take = (idx >= CNT_W'(offs))
                    && (rel < CNT_W'(rxf_pkg::MASK_BITS))
                    && mask[rel[4:0]];
      assign crc_seed = rx_sof ? rxf_pkg::CRC16_INIT : crc_r;
      assign crc_now = take ? crc16_byte(crc_seed, rx_data)
                            : crc_seed;

      // Running pattern CRC for this filter
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          crc_r <= rxf_pkg::CRC16_INIT;
        end else if (clk_en && rx_valid) begin
          crc_r <= crc_now;
        end
      end

      // Enabled, address type matches, CRC equal
      assign filt_hit[f] = cmd[rxf_pkg::BIT_CMD_EN]
                           && (cmd[rxf_pkg::BIT_CMD_MC] == is_mc)
                           && (crc_now == exp_crc);
    end
  endgenerate

  // A frame in progress counts only once its last byte arrives
  logic frame_end;
  assign frame_end = clk_en && rx_valid && rx_eof && long_enough
                     && (state_r != rxf_pkg::ST_IDLE || rx_sof);
  assign wake_hit = frame_end && wake_act && wake_addr_ok
                    && (|filt_hit);

  ////////////////////////////////////////////////////////////////////
  // Outputs

  logic accept_r;
  logic reject_r;
  logic irq_r;
  logic pme_r;

  // Normal reception stops while wake detection runs
  // Every last byte taken with clock enable high earns exactly one verdict, so nothing upstream waits
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      accept_r <= 1'b0;
      reject_r <= 1'b0;
    end else if (clk_en) begin
      accept_r <= 1'b0;
      reject_r <= 1'b0;
      if (clk_en && rx_valid && rx_eof) begin
        if (frame_end && !wake_act && addr_ok && bc_ok) begin
          accept_r <= 1'b1;
        end else begin
          reject_r <= 1'b1;
        end
      end
    end
  end

  // Report follows the sticky flag on the chosen output
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      pme_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= wake_rcvd_r && !wake_pme_r;
      pme_r <= wake_rcvd_r && wake_pme_r;
    end
  end

  assign frame_accept = accept_r;
  assign frame_reject = reject_r;
  assign host_irq = irq_r;
  assign power_event_output = pme_r;

endmodule // rxf_filter
